// ---- inc/vdcrb_pkg.sv ----
// Constants for the deserializer configuration register bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package vdcrb_pkg;

  // Sizes
  localparam int NPIN     = 8;
  localparam int CODE_W   = 6;
  localparam int NSTAT    = 16;
  localparam int NCTL     = 9;
  localparam int CTL_BASE = 32;
  localparam int CFG_W    = 31;
  localparam int TEST_W   = 8;
  localparam int PCFG_W   = NPIN * CODE_W;
  localparam int FMTL_W   = 4;

  // Register byte offsets
  localparam logic [7:0] A_CFG     = 8'h00;
  localparam logic [7:0] A_ANC     = 8'h04;
  localparam logic [7:0] A_TEST    = 8'h08;
  localparam logic [7:0] A_PIN0    = 8'h0C;
  localparam logic [7:0] A_PIN1    = 8'h10;
  localparam logic [7:0] A_STAT    = 8'h14;
  localparam logic [7:0] A_IRQ_ST  = 8'h18;
  localparam logic [7:0] A_IRQ_CLR = 8'h1C;
  localparam logic [7:0] A_IRQ_EN  = 8'h20;

  // Configuration word fields
  localparam int B_EDH_FORCE  = 0;
  localparam int B_EDH_EN     = 1;
  localparam int B_CRC_REPL   = 2;
  localparam int B_CKS_FORCE  = 3;
  localparam int B_EXTRACT    = 4;
  localparam int B_FCLK_EN    = 5;
  localparam int B_MSG_TRACK  = 6;
  localparam int B_MSG_FLUSH  = 7;
  localparam int B_FIFO_FLUSH = 8;
  localparam int B_VDEPTH     = 9;
  localparam int B_FMT_SET    = 12;
  localparam int B_SD_ONLY    = 17;
  localparam int B_HD_ONLY    = 18;
  localparam int B_FRM_MODE   = 19;
  localparam int B_FRM_EN     = 20;
  localparam int B_DESCR      = 21;
  localparam int B_NRZI       = 22;
  localparam int B_LSB_CLIP   = 23;
  localparam int B_SYNC_DET   = 24;
  localparam int B_DEDITHER   = 25;
  localparam int B_VDEDITHER  = 26;
  localparam int B_UNSCR      = 27;
  localparam int B_REFCLK     = 28;
  localparam int B_EXT_VCLK   = 30;

  // Test word fields
  localparam int B_TP_SEL  = 0;
  localparam int B_TPG_EN  = 6;
  localparam int B_CBAR_EN = 7;

  // Reset values
  localparam logic [CFG_W-1:0]  RST_CFG      = 31'h01F80002;
  localparam logic [15:0]       RST_ANC_ID   = 16'h0000;
  localparam logic [15:0]       RST_ANC_MASK = 16'hFFFF;
  localparam logic [TEST_W-1:0] RST_TEST     = 8'h00;
  localparam logic [PCFG_W-1:0] RST_PCFG     =
    {6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};

  // Status function codes (pin outputs)
  localparam int ST_F        = 0;
  localparam int ST_V        = 1;
  localparam int ST_H        = 2;
  localparam int ST_FMT_MSB  = 3;
  localparam int ST_LOCK     = 4;
  localparam int ST_CRC_ERR  = 5;
  localparam int ST_ANC_EMPT = 6;
  localparam int ST_EAV      = 7;
  localparam int ST_NSP      = 8;

  // Control functions: code CTL_BASE+j, position in {test, cfg}
  localparam int CTL_POS [NCTL] = '{0, 1, 3, 4, 20, 25, 26, 37, 38};

endpackage

// ---- inc/vdcrb_mfio_if.sv ----
// Link between the register bank and its multifunction port router.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface vdcrb_mfio_if;
  import vdcrb_pkg::*;
  logic [NSTAT-1:0]  status;
  logic [PCFG_W-1:0] pin_cfg;
  logic              clr;
  logic [NCTL-1:0]   ctl_val;
  logic [NCTL-1:0]   ctl_routed;

  modport bank (output status, output pin_cfg, output clr,
                input ctl_val, input ctl_routed);
  modport port (input status, input pin_cfg, input clr,
                output ctl_val, output ctl_routed);
endinterface
`default_nettype wire

// ---- design/vdcrb_mfio.sv ----
// Multifunction port router: eight pins, each set by a function code.
// Assumes pins come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module vdcrb_mfio (
  input  wire logic                       i_clk,
  input  wire logic                       i_arst_n,
  vdcrb_mfio_if.port                      bus,
  input  wire logic [vdcrb_pkg::NPIN-1:0] i_mfio,
  output logic      [vdcrb_pkg::NPIN-1:0] o_mfio,
  output logic      [vdcrb_pkg::NPIN-1:0] o_mfio_oe
);
  import vdcrb_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] filt;
    logic [NPIN-1:0] dout;
    logic [NPIN-1:0] oe;
    logic [NCTL-1:0] val;
    logic [NCTL-1:0] routed;
  } vdcrb_mfio_st_t;

  vdcrb_mfio_st_t st_ff;
  vdcrb_mfio_st_t nxt_st;

  always_comb begin
    logic [CODE_W-1:0] code;
    code = '0;
    nxt_st = st_ff;
    nxt_st.s1 = i_mfio;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.val = '0;
    nxt_st.routed = '0;
    for (int p = 0; p < NPIN; p++) begin
      code = bus.pin_cfg[p*CODE_W +: CODE_W];
      if (st_ff.s2[p] == st_ff.s3[p]) begin
        nxt_st.filt[p] = st_ff.s3[p];
      end
      // Status codes drive the pin, the rest leave it undriven
      if (code < CODE_W'(NSTAT)) begin
        nxt_st.oe[p] = 1'b1;
        nxt_st.dout[p] = bus.status[code[3:0]];
      end else begin
        nxt_st.oe[p] = 1'b0;
        nxt_st.dout[p] = 1'b0;
      end
      // Several pins on one control are ORed
      for (int j = 0; j < NCTL; j++) begin
        if (code == CODE_W'(CTL_BASE + j)) begin
          nxt_st.routed[j] = 1'b1;
          nxt_st.val[j] = nxt_st.val[j] | st_ff.filt[p];
        end
      end
    end
    if (bus.clr) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_mfio = st_ff.dout;
  assign o_mfio_oe = st_ff.oe;
  assign bus.ctl_val = st_ff.val;
  assign bus.ctl_routed = st_ff.routed;

endmodule
`default_nettype wire

// ---- design/vdcrb_bank.sv ----
// Configuration register bank with Wishbone slave, interrupt and port routing.
// Assumes core status arrives on i_clk; manual reset and pins are asynchronous.
// What this block does
// - Power-on pins 0..7: F, V, H, format MSB, lock, CRC error, ANC empty, EAV.
// - All single-bit functions are positive logic: one means on or set.
// - Status functions drive pins as outputs; control functions read pins as inputs.
// - Reset: ANC ID zero, mask all ones; EDH, framing, descrambler, NRZI on.
// - Reset: LSB clip and sync detect on; dither, TEST_PATTERN_GENERATOR, filter, unscrambled off.
// - Vertical de-dither is read-write, off at reset, routable as pin input.
// - New sync position flag is read-only, routable as pin output.
// - Power-on or manual reset clears all state; only manual reset zeroes check words.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vdcrb_bank (
  input  wire logic                         i_clk,
  input  wire logic                         i_arst_n,
  input  wire logic                         i_man_rst,
  input  wire logic                         i_wb_cyc,
  input  wire logic                         i_wb_stb,
  input  wire logic                         i_wb_we,
  input  wire logic [7:0]                   i_wb_adr,
  input  wire logic [3:0]                   i_wb_sel,
  input  wire logic [31:0]                  i_wb_dat,
  output logic      [31:0]                  o_wb_dat,
  output logic                              o_wb_ack,
  input  wire logic [vdcrb_pkg::NSTAT-1:0]  i_status,
  input  wire logic [vdcrb_pkg::FMTL_W-1:0] i_fmt_low,
  input  wire logic [vdcrb_pkg::NPIN-1:0]   i_mfio,
  output logic      [vdcrb_pkg::NPIN-1:0]   o_mfio,
  output logic      [vdcrb_pkg::NPIN-1:0]   o_mfio_oe,
  output logic      [vdcrb_pkg::CFG_W-1:0]  o_cfg,
  output logic      [15:0]                  o_anc_id,
  output logic      [15:0]                  o_anc_mask,
  output logic      [5:0]                   o_test_sel,
  output logic                              o_tpg_en,
  output logic                              o_cbar_filter_en,
  output logic                              o_irq,
  output logic                              o_core_clear
);
  import vdcrb_pkg::*;

  localparam int CW_W = TEST_W + CFG_W;

  typedef struct packed {
    logic [2:0]        sy;
    logic              rstf;
    logic              ack;
    logic [31:0]       rdat;
    logic [CFG_W-1:0]  cfg;
    logic [15:0]       anc_id;
    logic [15:0]       anc_mask;
    logic [TEST_W-1:0] test;
    logic [PCFG_W-1:0] pcfg;
    logic [NSTAT-1:0]  prev;
    logic [NSTAT-1:0]  irq_st;
    logic [NSTAT-1:0]  irq_en;
    logic [CFG_W-1:0]  ocfg;
    logic [TEST_W-1:0] otest;
    logic              irq;
    logic              live;
  } vdcrb_bank_t;

  localparam vdcrb_bank_t ST_RST = '{
    sy:       3'h0,
    rstf:     1'b0,
    ack:      1'b0,
    rdat:     32'h00000000,
    cfg:      RST_CFG,
    anc_id:   RST_ANC_ID,
    anc_mask: RST_ANC_MASK,
    test:     RST_TEST,
    pcfg:     RST_PCFG,
    prev:     16'h0000,
    irq_st:   16'h0000,
    irq_en:   16'h0000,
    ocfg:     RST_CFG,
    otest:    RST_TEST,
    irq:      1'b0,
    live:     1'b0
  };

  vdcrb_bank_t st_ff;
  vdcrb_bank_t nxt_st;

  vdcrb_mfio_if mfio_bus ();

  // Byte-lane merge for Wishbone sel
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic              req;
  logic              wr;
  logic [31:0]       cfg_w;
  logic [31:0]       anc_w;
  logic [31:0]       pin0_w;
  logic [31:0]       pin1_w;
  logic [31:0]       test_w;
  logic [31:0]       ien_w;
  logic [31:0]       rd_v;
  logic [NSTAT-1:0]  clr_m;
  logic [NSTAT-1:0]  ev;
  logic [CW_W-1:0]   cw;

  assign req = i_wb_cyc & i_wb_stb;
  // Write lands on the edge where the master sees ack
  assign wr = req & i_wb_we & st_ff.ack;

  always_comb begin
    cfg_w  = merge({1'b0, st_ff.cfg}, i_wb_dat, i_wb_sel);
    anc_w  = merge({st_ff.anc_mask, st_ff.anc_id}, i_wb_dat, i_wb_sel);
    test_w = merge({24'h000000, st_ff.test}, i_wb_dat, i_wb_sel);
    pin0_w = merge({8'h00, st_ff.pcfg[23:0]}, i_wb_dat, i_wb_sel);
    pin1_w = merge({8'h00, st_ff.pcfg[47:24]}, i_wb_dat, i_wb_sel);
    ien_w  = merge({16'h0000, st_ff.irq_en}, i_wb_dat, i_wb_sel);
  end

  // Read mux; write-only and unmapped offsets read zero
  always_comb begin
    case (i_wb_adr)
      A_CFG:    rd_v = {1'b0, st_ff.cfg};
      A_ANC:    rd_v = {st_ff.anc_mask, st_ff.anc_id};
      A_TEST:   rd_v = {24'h000000, st_ff.test};
      A_PIN0:   rd_v = {8'h00, st_ff.pcfg[23:0]};
      A_PIN1:   rd_v = {8'h00, st_ff.pcfg[47:24]};
      A_STAT:   rd_v = {12'h000, i_fmt_low, i_status};
      A_IRQ_ST: rd_v = {16'h0000, st_ff.irq_st};
      A_IRQ_EN: rd_v = {16'h0000, st_ff.irq_en};
      default:  rd_v = 32'h00000000;
    endcase
  end

  always_comb begin
    clr_m = '0;
    if (wr && i_wb_adr == A_IRQ_CLR) begin
      clr_m = i_wb_dat[NSTAT-1:0] & {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    end
  end

  // Rising edge of any status function is an interrupt event
  // Masked in the first cycle after reset: prev holds no true history yet
  assign ev = i_status & ~st_ff.prev & {NSTAT{st_ff.live}};

  // Pin-routed controls replace the register copy on the core side only
  always_comb begin
    cw = {st_ff.test, st_ff.cfg};
    for (int j = 0; j < NCTL; j++) begin
      if (mfio_bus.ctl_routed[j]) begin
        cw[CTL_POS[j]] = mfio_bus.ctl_val[j];
      end
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sy = {st_ff.sy[1:0], i_man_rst};
    if (st_ff.sy[1] == st_ff.sy[2]) begin
      nxt_st.rstf = st_ff.sy[2];
    end
    nxt_st.ack = req & ~st_ff.ack;
    if (req && !st_ff.ack) begin
      nxt_st.rdat = rd_v;
    end
    if (wr) begin
      // Status and interrupt status offsets take no write
      case (i_wb_adr)
        A_CFG: begin
          nxt_st.cfg = cfg_w[CFG_W-1:0];
        end
        A_ANC: begin
          nxt_st.anc_id = anc_w[15:0];
          nxt_st.anc_mask = anc_w[31:16];
        end
        A_TEST: begin
          nxt_st.test = test_w[TEST_W-1:0];
        end
        A_PIN0: begin
          nxt_st.pcfg[23:0] = pin0_w[23:0];
        end
        A_PIN1: begin
          nxt_st.pcfg[47:24] = pin1_w[23:0];
        end
        A_IRQ_EN: begin
          nxt_st.irq_en = ien_w[NSTAT-1:0];
        end
        default: begin
          nxt_st.cfg = st_ff.cfg;
        end
      endcase
    end
    nxt_st.prev = i_status;
    nxt_st.live = 1'b1;
    // Set beats clear in the same cycle
    nxt_st.irq_st = (st_ff.irq_st & ~clr_m) | ev;
    nxt_st.ocfg = cw[CFG_W-1:0];
    nxt_st.otest = cw[CW_W-1:CFG_W];
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_en);
    // Manual reset holds all but sy, rstf, ack and prev at defaults while high
    if (st_ff.rstf) begin
      nxt_st = ST_RST;
      nxt_st.sy = {st_ff.sy[1:0], i_man_rst};
      nxt_st.rstf = (st_ff.sy[1] == st_ff.sy[2]) ? st_ff.sy[2] : st_ff.rstf;
      // Bus keeps answering so a master never hangs; the write is dropped
      nxt_st.ack = req & ~st_ff.ack;
      nxt_st.prev = i_status;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mfio_bus.status = i_status;
  assign mfio_bus.pin_cfg = st_ff.pcfg;
  assign mfio_bus.clr = st_ff.rstf;

  vdcrb_mfio u_mfio (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .bus       (mfio_bus.port),
    .i_mfio    (i_mfio),
    .o_mfio    (o_mfio),
    .o_mfio_oe (o_mfio_oe)
  );

  assign o_wb_dat = st_ff.rdat;
  assign o_wb_ack = st_ff.ack;
  assign o_cfg = st_ff.ocfg;
  assign o_anc_id = st_ff.anc_id;
  assign o_anc_mask = st_ff.anc_mask;
  assign o_test_sel = st_ff.otest[B_TPG_EN-1:B_TP_SEL];
  assign o_tpg_en = st_ff.otest[B_TPG_EN];
  assign o_cbar_filter_en = st_ff.otest[B_CBAR_EN];
  assign o_irq = st_ff.irq;
  // Core clears its check words to zero while this is high
  assign o_core_clear = st_ff.rstf;

endmodule
`default_nettype wire

// ---- sim/vdcrb_host_model.sv ----
// Host-side model of the multifunction pins.
// Assumes the bank's output enable marks the pins that it drives.
`timescale 1ns/1ps
`default_nettype none
module vdcrb_host_model (
  input  wire logic [vdcrb_pkg::NPIN-1:0] i_dev,
  input  wire logic [vdcrb_pkg::NPIN-1:0] i_oe,
  input  wire logic [vdcrb_pkg::NPIN-1:0] i_val,
  output logic      [vdcrb_pkg::NPIN-1:0] o_pin
);
  // Host drives only free pins, so a wire never has two drivers
  assign o_pin = (i_oe & i_dev) | (~i_oe & i_val);
endmodule
`default_nettype wire

// ---- sim/vdcrb_monitor.sv ----
// Bus, reset and pin checks for the register bank.
// Assumes one clock and the default pin mapping after reset.
`timescale 1ns/1ps
`default_nettype none
module vdcrb_monitor (
  input wire logic                         i_clk,
  input wire logic                         i_arst_n,
  input wire logic                         i_wb_cyc,
  input wire logic                         i_wb_stb,
  input wire logic                         i_wb_we,
  input wire logic [7:0]                   i_wb_adr,
  input wire logic [31:0]                  o_wb_dat,
  input wire logic                         o_wb_ack,
  input wire logic [vdcrb_pkg::NSTAT-1:0]  i_status,
  input wire logic [vdcrb_pkg::FMTL_W-1:0] i_fmt_low,
  input wire logic [vdcrb_pkg::NPIN-1:0]   o_mfio,
  input wire logic [vdcrb_pkg::NPIN-1:0]   o_mfio_oe,
  input wire logic [vdcrb_pkg::CFG_W-1:0]  o_cfg,
  input wire logic [15:0]                  o_anc_id,
  input wire logic [15:0]                  o_anc_mask,
  input wire logic                         o_irq,
  input wire logic                         o_core_clear
);
  import vdcrb_pkg::*;
  logic req;
  logic rd;
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign rd  = req && !i_wb_we;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_latency: assert property (req |=> o_wb_ack) else $error("ack late");
  a_ack_unasked: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack) else $error("stray ack");
  a_unmapped_zero: assert property (rd && i_wb_adr > A_IRQ_EN |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_clr_reads_zero: assert property (rd && i_wb_adr == A_IRQ_CLR |=> o_wb_dat == 32'h0)
    else $error("clear register read not zero");
  a_status_read: assert property (rd && i_wb_adr == A_STAT
    |=> o_wb_dat == {12'h000, $past(i_fmt_low), $past(i_status)}) else $error("status read wrong");
  a_rst_dflt: assert property ($rose(i_arst_n) |-> o_cfg == RST_CFG && o_anc_id == 16'h0000
    && o_anc_mask == 16'hFFFF) else $error("reset defaults wrong");
  a_pin_dflt: assert property ($rose(i_arst_n) |=> o_mfio_oe == 8'hFF ##2
    o_mfio == $past(i_status[7:0])) else $error("default pins wrong");
  a_clear_dflt: assert property (o_core_clear && $past(o_core_clear)
    |-> o_cfg == RST_CFG && !o_irq) else $error("manual reset not clearing");
endmodule
bind vdcrb_bank vdcrb_monitor i_mon (.i_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .o_wb_dat, .o_wb_ack, .i_status, .i_fmt_low, .o_mfio, .o_mfio_oe, .o_cfg, .o_anc_id, .o_anc_mask,
  .o_irq, .o_core_clear);
`default_nettype wire

// ---- sim/video_deser_config_register_bank_tb_top.sv ----
// Directed bench for the register bank over classic Wishbone.
// Assumes the host pin model and the bound monitor are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module video_deser_config_register_bank_tb_top;
  import vdcrb_pkg::*;
  localparam logic [31:0] CFG_VD = {1'b0, RST_CFG} | (32'h1 << B_VDEDITHER);
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic             man_rst = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h0;
  logic [15:0]      status = 16'h00A5;
  logic [3:0]       fmt = 4'h9;
  logic [7:0]       host_val = 8'h00;
  logic [31:0]      rdat;
  logic             ack, test_pattern_generator, cbar, irq, cclr;
  logic [7:0]       pin, dev, oe;
  logic [CFG_W-1:0] cfg;
  logic [15:0]      anc_id, anc_mask;
  logic [5:0]       tsel;
  int               n_fail = 0;
  int               cmp_count = 0;
  always #10 clk = ~clk;
  vdcrb_bank i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_man_rst(man_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_status(status), .i_fmt_low(fmt), .i_mfio(pin), .o_mfio(dev), .o_mfio_oe(oe), .o_cfg(cfg),
    .o_anc_id(anc_id), .o_anc_mask(anc_mask), .o_test_sel(tsel), .o_tpg_en(test_pattern_generator),
    .o_cbar_filter_en(cbar), .o_irq(irq), .o_core_clear(cclr));
  vdcrb_host_model i_host (.i_dev(dev), .i_oe(oe), .i_val(host_val), .o_pin(pin));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    tick(6);
    arst_n <= 1'b1;
    tick(3);
    chk({1'b0, cfg}, {1'b0, RST_CFG});
    chk({anc_mask, anc_id}, 32'hFFFF0000);
    chk({tsel, test_pattern_generator, cbar}, 8'h00);
    chk({oe, pin}, {8'hFF, status[7:0]});
    rdchk(A_CFG, {1'b0, RST_CFG});
    rdchk(A_ANC, 32'hFFFF0000);
    rdchk(A_TEST, 32'h0);
    rdchk(A_PIN0, {8'h00, RST_PCFG[23:0]});
    rdchk(A_PIN1, {8'h00, RST_PCFG[47:24]});
    $display("test reset_defaults done");
    wr(A_CFG, CFG_VD);
    rdchk(A_CFG, CFG_VD);
    chk({1'b0, cfg}, CFG_VD);
    wr(A_ANC, 32'h1234ABCD);
    rdchk(A_ANC, 32'h1234ABCD);
    chk({anc_mask, anc_id}, 32'h1234ABCD);
    wr(A_STAT, 32'hFFFFFFFF);
    rdchk(A_STAT, {12'h000, fmt, status});
    rdchk(8'h40, 32'h0);
    wr(A_TEST, 32'h000000C5);
    rdchk(A_TEST, 32'h000000C5);
    chk({tsel, test_pattern_generator, cbar}, 8'h17);
    $display("test access done");
    wr(A_PIN0, {8'h00, 6'h03, 6'h02, 6'h08, 6'h25});
    host_val <= 8'h01;
    status[8] <= 1'b1;
    tick(8);
    chk({oe[1:0], pin[1:0]}, 4'b1011);
    chk(cfg[B_DEDITHER], 1'b1);
    rdchk(A_CFG, CFG_VD);
    host_val <= 8'h00;
    tick(8);
    chk(cfg[B_DEDITHER], 1'b0);
    $display("test pin_routing done");
    wr(A_IRQ_CLR, 32'h0000FFFF);
    wr(A_IRQ_EN, 32'h00000200);
    status[9] <= 1'b1;
    tick(3);
    chk(irq, 1'b1);
    wr(A_IRQ_ST, 32'h0);
    rdchk(A_IRQ_ST, 32'h200);
    wr(A_IRQ_EN, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    wr(A_IRQ_EN, 32'h200);
    tick(2);
    chk(irq, 1'b1);
    wr(A_IRQ_CLR, 32'h200);
    tick(2);
    chk(irq, 1'b0);
    rdchk(A_IRQ_ST, 32'h0);
    rdchk(A_IRQ_CLR, 32'h0);
    $display("test interrupt done");
    man_rst <= 1'b1;
    tick(8);
    chk(cclr, 1'b1);
    chk({1'b0, cfg}, {1'b0, RST_CFG});
    man_rst <= 1'b0;
    tick(8);
    chk({cclr, irq}, 2'b00);
    chk({oe, pin}, {8'hFF, status[7:0]});
    chk({tsel, test_pattern_generator, cbar}, 8'h00);
    rdchk(A_CFG, {1'b0, RST_CFG});
    rdchk(A_PIN0, {8'h00, RST_PCFG[23:0]});
    rdchk(A_IRQ_EN, 32'h0);
    $display("test manual_reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
